//--- design/pcbs_pkg.sv
/*
  Package for the power control and battery switchover block: special
  function register addresses, field positions, reset values and types.
  Assumes an 8-bit special function register space driven by the core.
*/
`default_nettype none

package pcbs_pkg;

  // Register addresses in the core's special function register space
  localparam logic [7:0] ADDR_WRITE_UNLOCK_KEY     = 8'hc1;
  localparam logic [7:0] ADDR_POWER_CONTROL        = 8'hc5;
  localparam logic [7:0] ADDR_PSM_ENABLE           = 8'hec;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG    = 8'hf4;
  localparam logic [7:0] ADDR_SWITCHOVER_CONFIG    = 8'hf5;
  localparam logic [7:0] ADDR_PSM_FLAGS            = 8'hf8;
  localparam logic [7:0] ADDR_RETAINED_SCRATCH_3   = 8'hfd;
  localparam logic [7:0] ADDR_RETAINED_SCRATCH_4   = 8'hfe;
  localparam logic [7:0] ADDR_INTERRUPT_PIN_CONFIG = 8'hff;

  // Unlock value for the power control register
  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'ha7;

  // Power control field positions
  localparam int PWR_RSVD_HI_BIT  = 7;
  localparam int PWR_METER_OFF_BIT = 6;
  localparam int PWR_KEEP_ZERO_BIT = 5;
  localparam int PWR_CORE_OFF_BIT  = 4;
  localparam int PWR_DIV_LSB       = 0;

  // Other field positions
  localparam int PSM_RESTORED_BIT   = 7;
  localparam int PSM_SWITCHOVER_BIT = 1;
  localparam int PERIPHERAL_SOURCE_BIT = 6;
  localparam int INT1_CFG_LSB       = 0;

  // Reset values
  localparam logic [2:0] CORE_CLOCK_DIVIDE_RST = 3'h2;
  localparam logic [1:0] SWITCHOVER_SELECT_RST = 2'h0;
  localparam logic [2:0] EXT_INT1_CONFIG_RST   = 3'h0;
  localparam logic [7:0] SCRATCH_RST           = 8'h00;

  // Switchover select codes and the interrupt pin battery code
  localparam logic [1:0] SEL_MAIN_ONLY    = 2'h0;
  localparam logic [1:0] SEL_MAIN_MONITOR = 2'h1;
  localparam logic [1:0] INT1_BATT_CODE   = 2'h1;

  // Supply source state, Gray along main -> battery -> main
  typedef enum logic [0:0] {
    SRC_MAIN    = 1'b0,
    SRC_BATTERY = 1'b1
  } pcbs_src_e;

  // Stored power control fields
  typedef struct packed {
    logic       meter_off;
    logic       keep_zero;
    logic       core_shutdown;
    logic [2:0] core_clock_divide;
  } pcbs_power_control_s;

endpackage : pcbs_pkg

`default_nettype wire

//--- design/pcbs_power_switchover.sv
/*
  Power control register, retained scratch bytes three and four, and the
  main supply / battery switchover controller with its latched flags.
  Assumes the core drives single-cycle synchronous register writes and
  reads, and that supply comparators and the battery control pin are
  already synchronous to clk_sys_i.
*/
// Behaviour
// - Scratch bytes are 8-bit, kept in power saving
// - Scratch cleared only when both supplies lost
// - Meter-off bit 6 powers down metering
// - Core-off bit 4 in mode one enters two
// - Divide field: 4.096 MHz over 2^n, reset 010
// - Switchover on after reset; select bit 1 disables
// - Select 01 adds low monitor input trigger
// - Select 00 uses low main supply trigger
// - Battery pin falling edge forces switchover when enabled
// - Metering converters unavailable while on battery
// - Enableable switchover and restore interrupts, ORed onto one output
// - Select 1x disables switchover entirely
// - Return to main when all triggers false, or at once under select 1x
// - Flags latched, cleared by writing zero
`timescale 1ns/1ps
`default_nettype none

module pcbs_power_switchover (
  // Clock and resets
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       supplies_lost_i,
  // Register port from the core
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  // Supply monitors and pins
  input  wire logic       main_low_i,
  input  wire logic       monitor_low_i,
  input  wire logic       battery_control_pin_i,
  input  wire logic       low_power_mode_one_i,
  // Power controls
  output logic            internal_supply_main_o,
  output logic            meter_power_down_o,
  output logic            meter_adc_available_o,
  output logic            enter_low_power_mode_two_o,
  output logic      [2:0] core_clock_divide_o,
  output logic            psm_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  pcbs_pkg::pcbs_power_control_s pwr_r;
  logic                          unlock_r;
  logic [7:0]                    retained_scratch_three_r;
  logic [7:0]                    retained_scratch_four_r;
  logic [1:0]                    switchover_select_r;
  logic [2:0]                    ext_int1_config_r;
  logic                          en_restored_r;
  logic                          en_switchover_r;
  logic                          flag_restored_r;
  logic                          flag_switchover_r;
  logic                          pin_prev_r;
  pcbs_pkg::pcbs_src_e           src_r;
  pcbs_pkg::pcbs_src_e           src_nxt;
  logic [7:0]                    rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire wr_key      = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_WRITE_UNLOCK_KEY);
  wire wr_pwr      = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_POWER_CONTROL);
  wire wr_en       = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_PSM_ENABLE);
  wire wr_cfg      = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_SWITCHOVER_CONFIG);
  wire wr_flags    = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_PSM_FLAGS);
  wire wr_scr3     = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_RETAINED_SCRATCH_3);
  wire wr_scr4     = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_RETAINED_SCRATCH_4);
  wire wr_intpin   = sfr_wr_i && (sfr_addr_i == pcbs_pkg::ADDR_INTERRUPT_PIN_CONFIG);
  wire key_match   = wr_key && (sfr_wdata_i == pcbs_pkg::UNLOCK_KEY_VALUE);
  wire wr_pwr_ok   = wr_pwr && unlock_r;

  ////////////////////////////////////////////////////////////////////////////
  // Switchover triggers
  wire sel_disabled = switchover_select_r[1];
  wire monitor_en   = (switchover_select_r == pcbs_pkg::SEL_MAIN_MONITOR);
  wire main_en      = !sel_disabled;
  wire pin_en       = !sel_disabled &&
                      (ext_int1_config_r[1:0] == pcbs_pkg::INT1_BATT_CODE);
  wire pin_fall     = pin_prev_r && !battery_control_pin_i;
  wire go_battery   = (main_en && main_low_i) || (monitor_en && monitor_low_i) ||
                      (pin_en && pin_fall);
  // Pin must be high again before leaving the battery
  wire hold_battery = (main_en && main_low_i) || (monitor_en && monitor_low_i) ||
                      (pin_en && !battery_control_pin_i);
  wire to_battery   = (src_r == pcbs_pkg::SRC_MAIN) && (src_nxt == pcbs_pkg::SRC_BATTERY);
  wire to_main      = (src_r == pcbs_pkg::SRC_BATTERY) && (src_nxt == pcbs_pkg::SRC_MAIN);

  // Next supply source; disabling forces the main supply back
  always_comb begin
    src_nxt = src_r;
    unique case (src_r)
      pcbs_pkg::SRC_MAIN: begin
        if (go_battery) begin
          src_nxt = pcbs_pkg::SRC_BATTERY;
        end
      end
      pcbs_pkg::SRC_BATTERY: begin
        if (sel_disabled || !hold_battery) begin
          src_nxt = pcbs_pkg::SRC_MAIN;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source state and pin history; main supply after reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      src_r      <= pcbs_pkg::SRC_MAIN;
      pin_prev_r <= 1'b1;
    end else begin
      src_r      <= src_nxt;
      pin_prev_r <= battery_control_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key unlock: one write only, any following write consumes it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      unlock_r <= 1'b0;
    end else if (sfr_wr_i) begin
      unlock_r <= key_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pwr_r <= '{meter_off: 1'b0, keep_zero: 1'b0, core_shutdown: 1'b0,
                 core_clock_divide: pcbs_pkg::CORE_CLOCK_DIVIDE_RST};
    end else if (wr_pwr_ok) begin
      pwr_r.meter_off         <= sfr_wdata_i[pcbs_pkg::PWR_METER_OFF_BIT];
      pwr_r.keep_zero         <= sfr_wdata_i[pcbs_pkg::PWR_KEEP_ZERO_BIT];
      pwr_r.core_shutdown     <= sfr_wdata_i[pcbs_pkg::PWR_CORE_OFF_BIT];
      pwr_r.core_clock_divide <= sfr_wdata_i[pcbs_pkg::PWR_DIV_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and enables
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      switchover_select_r <= pcbs_pkg::SWITCHOVER_SELECT_RST;
      ext_int1_config_r   <= pcbs_pkg::EXT_INT1_CONFIG_RST;
      en_restored_r       <= 1'b0;
      en_switchover_r     <= 1'b0;
    end else begin
      if (wr_cfg) begin
        switchover_select_r <= sfr_wdata_i[1:0];
      end
      if (wr_intpin) begin
        ext_int1_config_r <= sfr_wdata_i[pcbs_pkg::INT1_CFG_LSB +: 3];
      end
      if (wr_en) begin
        en_restored_r   <= sfr_wdata_i[pcbs_pkg::PSM_RESTORED_BIT];
        en_switchover_r <= sfr_wdata_i[pcbs_pkg::PSM_SWITCHOVER_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags; a new event beats a clearing write in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flag_restored_r   <= 1'b0;
      flag_switchover_r <= 1'b0;
    end else begin
      if (to_main) begin
        flag_restored_r <= 1'b1;
      end else if (wr_flags && !sfr_wdata_i[pcbs_pkg::PSM_RESTORED_BIT]) begin
        flag_restored_r <= 1'b0;
      end
      if (to_battery) begin
        flag_switchover_r <= 1'b1;
      end else if (wr_flags && !sfr_wdata_i[pcbs_pkg::PSM_SWITCHOVER_BIT]) begin
        flag_switchover_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retained scratch bytes: system reset does not touch them, only the
  // loss of both supplies clears them
  always_ff @(posedge clk_sys_i) begin
    if (supplies_lost_i) begin
      retained_scratch_three_r <= pcbs_pkg::SCRATCH_RST;
      retained_scratch_four_r <= pcbs_pkg::SCRATCH_RST;
    end else begin
      if (wr_scr3) begin
        retained_scratch_three_r <= sfr_wdata_i;
      end
      if (wr_scr4) begin
        retained_scratch_four_r <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  logic [7:0] pwr_read;
  logic [7:0] flags_read;
  logic [7:0] en_read;

  always_comb begin
    pwr_read = 8'h00;
    pwr_read[pcbs_pkg::PWR_RSVD_HI_BIT]   = 1'b1;
    pwr_read[pcbs_pkg::PWR_METER_OFF_BIT] = pwr_r.meter_off;
    pwr_read[pcbs_pkg::PWR_KEEP_ZERO_BIT] = pwr_r.keep_zero;
    pwr_read[pcbs_pkg::PWR_CORE_OFF_BIT]  = pwr_r.core_shutdown;
    pwr_read[pcbs_pkg::PWR_DIV_LSB +: 3]  = pwr_r.core_clock_divide;
    flags_read = 8'h00;
    flags_read[pcbs_pkg::PSM_RESTORED_BIT]   = flag_restored_r;
    flags_read[pcbs_pkg::PSM_SWITCHOVER_BIT] = flag_switchover_r;
    en_read = 8'h00;
    en_read[pcbs_pkg::PSM_RESTORED_BIT]   = en_restored_r;
    en_read[pcbs_pkg::PSM_SWITCHOVER_BIT] = en_switchover_r;
    unique case (sfr_addr_i)
      pcbs_pkg::ADDR_POWER_CONTROL:        rd_mux = pwr_read;
      pcbs_pkg::ADDR_PSM_ENABLE:           rd_mux = en_read;
      pcbs_pkg::ADDR_PSM_FLAGS:            rd_mux = flags_read;
      pcbs_pkg::ADDR_SWITCHOVER_CONFIG:    rd_mux = {6'h00, switchover_select_r};
      pcbs_pkg::ADDR_INTERRUPT_PIN_CONFIG: rd_mux = {5'h00, ext_int1_config_r};
      pcbs_pkg::ADDR_RETAINED_SCRATCH_3:   rd_mux = retained_scratch_three_r;
      pcbs_pkg::ADDR_RETAINED_SCRATCH_4:   rd_mux = retained_scratch_four_r;
      pcbs_pkg::ADDR_PERIPHERAL_CONFIG: begin
        rd_mux = 8'h00;
        rd_mux[pcbs_pkg::PERIPHERAL_SOURCE_BIT] = (src_r == pcbs_pkg::SRC_MAIN);
      end
      default:                             rd_mux = 8'h00;
    endcase
  end

  // Read data registered, valid the cycle after sfr_rd_i
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd_i) begin
      rdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  wire on_main = (src_r == pcbs_pkg::SRC_MAIN);

  assign sfr_rdata_o                = rdata_r;
  assign internal_supply_main_o     = on_main;
  assign meter_power_down_o         = pwr_r.meter_off || !on_main;
  assign meter_adc_available_o      = on_main && !pwr_r.meter_off;
  assign enter_low_power_mode_two_o = pwr_r.core_shutdown && low_power_mode_one_i;
  assign core_clock_divide_o        = pwr_r.core_clock_divide;
  assign psm_irq_o                  = (flag_restored_r && en_restored_r) ||
                                      (flag_switchover_r && en_switchover_r);

endmodule // pcbs_power_switchover

`default_nettype wire

//--- testbench/pcbs_checker.sv
/* Port-level properties of the power switchover block.
   Assumes it is bound into pcbs_power_switchover and that writes land at their own edge. */
`timescale 1ns/1ps
`default_nettype none
module pcbs_checker (
  // Clock and register port
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // Supply monitors and controls
  input wire logic       main_low_i,
  input wire logic       monitor_low_i,
  input wire logic       battery_control_pin_i,
  input wire logic       internal_supply_main_o,
  input wire logic       meter_power_down_o,
  input wire logic       meter_adc_available_o,
  input wire logic [2:0] core_clock_divide_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of key, select and pin config; any write spends the key
  logic       unlock_r;
  logic [1:0] sel_r;
  logic [1:0] int1_r;
  wire  logic [2:0] wdiv = sfr_wdata_i[2:0];
  wire  logic key_wr = sfr_wr_i && sfr_addr_i == 8'hc1 && sfr_wdata_i == pcbs_pkg::UNLOCK_KEY_VALUE;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      unlock_r <= 1'b0;
      sel_r    <= 2'h0;
      int1_r   <= 2'h0;
    end else if (sfr_wr_i) begin
      unlock_r <= key_wr;
      if (sfr_addr_i == 8'hf5) sel_r <= sfr_wdata_i[1:0];
      if (sfr_addr_i == 8'hff) int1_r <= sfr_wdata_i[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Triggers are judged only on edges without a write, so config is settled
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence quiet_s; !sfr_wr_i; endsequence
  sequence pin_fall_s; int1_r == 2'h1 && !sel_r[1] && $fell(battery_control_pin_i); endsequence
  reset_values_a: assert property ($rose(rst_n_i) |-> core_clock_divide_o == 3'h2 && internal_supply_main_o)
    else $error("reset values wrong");
  locked_write_a: assert property (sfr_wr_i && sfr_addr_i == 8'hc5 && !unlock_r |=> $stable(core_clock_divide_o))
    else $error("locked power control write took effect");
  unlocked_write_a: assert property (sfr_wr_i && sfr_addr_i == 8'hc5 && unlock_r |=> core_clock_divide_o == $past(wdiv))
    else $error("unlocked power control write lost");
  battery_effects_a: assert property (!internal_supply_main_o |-> !meter_adc_available_o && meter_power_down_o)
    else $error("metering active on battery");
  main_low_a: assert property (quiet_s ##0 (main_low_i && !sel_r[1]) |=> !internal_supply_main_o)
    else $error("no switchover on low main");
  monitor_low_a: assert property (quiet_s ##0 (monitor_low_i && sel_r == 2'h1) |=> !internal_supply_main_o)
    else $error("no switchover on low monitor");
  pin_fall_a: assert property (quiet_s ##0 pin_fall_s |=> !internal_supply_main_o)
    else $error("no switchover on pin fall");
  return_main_a: assert property (quiet_s ##0 (!main_low_i && !monitor_low_i && battery_control_pin_i)
    |=> internal_supply_main_o)
    else $error("no return to main");
  source_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'hf4 |=>
    sfr_rdata_o == {1'b0, $past(internal_supply_main_o), 6'h00})
    else $error("source flag read wrong");
endmodule // pcbs_checker
bind pcbs_power_switchover pcbs_checker chk_u (.clk_sys_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
  .sfr_rd_i, .sfr_rdata_o, .main_low_i, .monitor_low_i, .battery_control_pin_i, .internal_supply_main_o,
  .meter_power_down_o, .meter_adc_available_o, .core_clock_divide_o);
`default_nettype wire

//--- testbench/pcbs_supply_model.sv
/* Main supply, monitor input and battery control pin as seen by the block.
   Assumes the testbench commands levels; outputs move just after the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module pcbs_supply_model (
  // Clock and wanted conditions
  input  wire logic clk_i,
  input  wire logic main_low_cmd_i,
  input  wire logic monitor_low_cmd_i,
  input  wire logic pin_cmd_i,
  // Comparator and pin levels
  output var logic  main_low_o,
  output var logic  monitor_low_o,
  output var logic  pin_o
);
  // Comparators lag the supply by one cycle; pin idles high so only a real drop is an edge
  initial begin
    main_low_o = 1'b0;
    monitor_low_o = 1'b0;
    pin_o = 1'b1;
  end
  always @(posedge clk_i) begin
    main_low_o    <= #1 main_low_cmd_i;
    monitor_low_o <= #1 monitor_low_cmd_i;
    pin_o         <= #1 pin_cmd_i;
  end
endmodule // pcbs_supply_model
`default_nettype wire

//--- testbench/power_control_battery_switchover_tb_top.sv
/* Self-checking bench for pcbs_power_switchover and its supply model.
   Assumes a 40 MHz clock and single-cycle register strobes. */
`timescale 1ns/1ps
`default_nettype none
module power_control_battery_switchover_tb_top;
  // Stimulus, design outputs and counters
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       supplies_lost_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       sfr_rd_i = 1'b0;
  logic       low_power_mode_one_i = 1'b0;
  logic       main_cmd = 1'b0;
  logic       mon_cmd = 1'b0;
  logic       pin_cmd = 1'b1;
  wire logic [7:0] sfr_rdata_o;
  wire logic [2:0] core_clock_divide_o;
  wire logic main_low_i, monitor_low_i, battery_control_pin_i, internal_supply_main_o;
  wire logic meter_power_down_o, meter_adc_available_o, enter_low_power_mode_two_o, psm_irq_o;
  int errors = 0;
  int checks_done = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  pcbs_power_switchover dut_u (.clk_sys_i, .rst_n_i, .supplies_lost_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rd_i, .sfr_rdata_o, .main_low_i, .monitor_low_i, .battery_control_pin_i, .low_power_mode_one_i,
    .internal_supply_main_o, .meter_power_down_o, .meter_adc_available_o, .enter_low_power_mode_two_o,
    .core_clock_divide_o, .psm_irq_o);
  pcbs_supply_model model_u (.clk_i(clk_sys_i), .main_low_cmd_i(main_cmd), .monitor_low_cmd_i(mon_cmd),
    .pin_cmd_i(pin_cmd), .main_low_o(main_low_i), .monitor_low_o(monitor_low_i), .pin_o(battery_control_pin_i));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict, compare and register access; strobes rise and fall 1 ns after an edge
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checks_done++;
    if (act !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 sfr_wr_i = 1'b1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    @(posedge clk_sys_i);
    #1 sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    #1 sfr_rd_i = 1'b1;
    sfr_addr_i = a;
    @(posedge clk_sys_i);
    #1 sfr_rd_i = 1'b0;
    chk(sfr_rdata_o, exp);
  endtask
  task automatic pwr(input logic [7:0] d);
    wr(8'hc1, 8'ha7);
    wr(8'hc5, d);
  endtask
  // Bounded wait for the supply source; a hang ends the run
  task automatic wait_src(input logic exp);
    for (int n = 0; internal_supply_main_o !== exp; n++) begin
      if (n == 8) begin
        errors++;
        $display("mismatch at %0t: supply source stuck", $time);
        end_sim();
      end
      @(posedge clk_sys_i);
      #1;
    end
    chk({7'h0, internal_supply_main_o}, {7'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    supplies_lost_i = 1'b0;
    rd(8'hc5, 8'h82);
    rd(8'hf4, 8'h40);
    rd(8'hf5, 8'h00);
    rd(8'hfd, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hfd, 8'ha5);
    wr(8'hfe, 8'h5a);
    wr(8'hc5, 8'h10);
    rd(8'hc5, 8'h82);
    pwr(8'h43);
    rd(8'hc5, 8'hc3);
    chk({7'h0, meter_power_down_o}, 8'h01);
    wr(8'hc1, 8'ha7);
    wr(8'hfd, 8'h3c);
    wr(8'hc5, 8'h05);
    rd(8'hc5, 8'hc3);
    for (int d = 0; d < 8; d++) begin
      pwr({5'h0, d[2:0]});
      chk({5'h0, core_clock_divide_o}, {5'h0, d[2:0]});
    end
    pwr(8'h10);
    rd(8'hc5, 8'h90);
    chk({7'h0, enter_low_power_mode_two_o}, 8'h00);
    low_power_mode_one_i = 1'b1;
    @(posedge clk_sys_i);
    #1 chk({7'h0, enter_low_power_mode_two_o}, 8'h01);
    low_power_mode_one_i = 1'b0;
    // Software reset keeps the scratch bytes; losing both supplies clears them
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    rd(8'hc5, 8'h82);
    rd(8'hfd, 8'h3c);
    rd(8'hfe, 8'h5a);
    supplies_lost_i = 1'b1;
    @(posedge clk_sys_i);
    #1 supplies_lost_i = 1'b0;
    rd(8'hfe, 8'h00);
    // Low main with the default select, flags and interrupt
    wr(8'hec, 8'h82);
    rd(8'hec, 8'h82);
    main_cmd = 1'b1;
    wait_src(1'b0);
    rd(8'hf4, 8'h00);
    chk({6'h0, meter_adc_available_o, psm_irq_o}, 8'h01);
    main_cmd = 1'b0;
    wait_src(1'b1);
    chk({6'h0, meter_adc_available_o, meter_power_down_o}, 8'h02);
    rd(8'hf8, 8'h82);
    wr(8'hf8, 8'h00);
    rd(8'hf8, 8'h00);
    chk({7'h0, psm_irq_o}, 8'h00);
    // Monitor trigger only under select 01
    mon_cmd = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 chk({7'h0, internal_supply_main_o}, 8'h01);
    wr(8'hf5, 8'h01);
    wait_src(1'b0);
    mon_cmd = 1'b0;
    wait_src(1'b1);
    // Select 1x keeps the main supply
    for (int s = 2; s < 4; s++) begin
      wr(8'hf5, {6'h0, s[1:0]});
      main_cmd = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1 chk({7'h0, internal_supply_main_o}, 8'h01);
      main_cmd = 1'b0;
    end
    wr(8'hf5, 8'h00);
    // Pin ignored until configured, then each x01 code arms it
    pin_cmd = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 chk({7'h0, internal_supply_main_o}, 8'h01);
    pin_cmd = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(8'hff, {5'h0, k[0], 2'h1});
      pin_cmd = 1'b0;
      wait_src(1'b0);
      pin_cmd = 1'b1;
      wait_src(1'b1);
    end
    end_sim();
  end
endmodule // power_control_battery_switchover_tb_top
`default_nettype wire
